// >>> pscr_host.sv
// Host-side model that drives the register port of the bank
`timescale 1ns/1ps
`default_nettype none
module pscr_host
    import pscr_pkg::*;
(
    // Clock and register port
    input  wire logic        clk,
    output var  pscr_req_t   req,
    input  wire logic [31:0] rdata
);
    initial req = '0;

    // Request holds through the taking edge, then is dropped for a cycle
    task automatic xfer(input logic w, input logic [15:0] a,
                        input logic [31:0] d, output logic [31:0] q);
        @(posedge clk);
        #1 req = '{wr: w, rd: !w, addr: a, wdata: d};
        @(negedge clk);
        q = rdata;
        @(posedge clk);
        #1 req = '0;
    endtask : xfer
endmodule : pscr_host
`default_nettype wire

// >>> pscr_pkg.sv
// Package for the system control register bank: offsets, fields, resets
package pscr_pkg;

    // Register offsets (byte addresses on the internal register port)
    localparam logic [15:0] OFS_STANDBY_RAIL    = 16'h80ac;
    localparam logic [15:0] OFS_XFER_CRC        = 16'h80b0;
    localparam logic [15:0] OFS_MODE_CMD        = 16'h80b4;
    localparam logic [15:0] OFS_BLANK_A         = 16'h80b8;
    localparam logic [15:0] OFS_BLANK_B         = 16'h80bc;
    localparam logic [15:0] OFS_SYS_CRC         = 16'h80c0;
    localparam logic [15:0] OFS_SYS_CRC_EXP     = 16'h80c4;
    localparam logic [15:0] OFS_SYS_CRC_POLY    = 16'h80c8;
    localparam logic [15:0] OFS_WAKE_FUNC       = 16'h80cc;
    localparam logic [15:0] OFS_CRC_PERIOD_EN   = 16'h80d0;
    localparam logic [15:0] OFS_THRESH_TYPE     = 16'h80d4;
    localparam logic [15:0] OFS_FUSE_PERIOD     = 16'h80d8;
    localparam logic [15:0] OFS_PIN_OVERRIDE    = 16'h80f0;

    // Reset values
    localparam logic        RST_RAIL_TWO_KEEP   = 1'b1;
    localparam logic [3:0]  RST_BLANK_CODE      = 4'h2;
    localparam logic [15:0] RST_CRC_SEED        = 16'h5555;
    localparam logic [15:0] RST_CRC_POLY        = 16'h90d9;
    localparam logic [9:0]  RST_FUSE_PERIOD     = 10'h096;

    // Field widths and counts
    localparam int BLANK_FIELDS   = 14;
    localparam int BLANK_PER_REG  = 7;
    localparam int MON_A_LSB      = 0;
    localparam int MON_B_LSB      = 2;

    // Mode command codes
    localparam logic [3:0] CMD_SELF_CHECK          = 4'h1;
    localparam logic [3:0] power_down_entry_code   = 4'h2;
    localparam logic [3:0] standby_entry_code      = 4'h4;
    localparam logic [3:0] ramp_up_entry_code      = 4'h8;

    // Blanking time table (us)
    localparam int BLANK_STEP_US  = 16;
    localparam int BLANK_LIN_MAX  = 12;
    localparam int BLANK_D_US     = 240;
    localparam int BLANK_E_US     = 288;
    localparam int BLANK_F_US     = 352;

    // Timing
    localparam int CLK_MHZ        = 50;
    localparam int MS_US          = 1000;
    localparam int CYC_PER_US     = CLK_MHZ;

    typedef enum logic [2:0] {
        MODE_RAMP_UP    = 3'b000,
        MODE_ACTIVE     = 3'b001,
        MODE_STANDBY    = 3'b011,
        MODE_POWER_DOWN = 3'b010,
        MODE_SELF_CHECK = 3'b110
    } pscr_mode_t;

    // Register access request from the serial front end
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [15:0] addr;
        logic [31:0] wdata;
    } pscr_req_t;

    // Per-monitor threshold enables
    typedef struct packed {
        logic uv_en;
        logic ov_en;
    } pscr_thr_t;

endpackage : pscr_pkg

// >>> pscr_regs.sv
// System control register bank: mode command, CRCs, blanking, pin override
`timescale 1ns/1ps
`default_nettype none
module pscr_regs
    import pscr_pkg::*;
(
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst,
    // Register port from the serial front end
    input  wire pscr_req_t   req,
    output logic [31:0]      rdata,
    // Serial transfer CRC from the serial front end
    input  wire logic        xfer_crc_vld,
    input  wire logic [15:0] xfer_crc,
    // Snapshot of system registers to be covered by the CRC
    input  wire logic [31:0] sys_word,
    // Normal pin drive from the fault logic
    input  wire logic        fault_n_norm,
    input  wire logic        status_n_norm,
    // Outputs to the rest of the device
    output pscr_mode_t       mode,
    output logic             rail_two_standby_keep,
    output logic             wake_input_event_select,
    output pscr_thr_t        monitor_a_threshold_type,
    output pscr_thr_t        monitor_b_threshold_type,
    output logic [BLANK_FIELDS*9-1:0] blank_cycles_us,
    output logic             fuse_check_start,
    output logic             sys_crc_fault,
    output logic             fault_n_pin,
    output logic             status_n_pin
);

    // Configuration state
    logic        keep_r, keep_nxt;
    logic [3:0]  cmd_r, cmd_nxt;
    logic [BLANK_FIELDS*4-1:0] blank_r, blank_nxt;
    logic [15:0] xcrc_r, xcrc_nxt;
    logic [15:0] scrc_r, scrc_nxt;
    logic [15:0] exp_r, exp_nxt;
    logic [15:0] seed_r, seed_nxt;
    logic [15:0] poly_r, poly_nxt;
    logic        wake_r, wake_nxt;
    logic        crc_en_r, crc_en_nxt;
    logic [3:0]  thr_r, thr_nxt;
    logic [9:0]  fuse_r, fuse_nxt;
    logic [3:0]  pin_r, pin_nxt;
    pscr_mode_t  mode_r, mode_nxt;
    logic        fault_r, fault_nxt;

    // Timebase state
    logic [5:0]  us_cnt_r, us_cnt_nxt;
    logic [9:0]  ms_cnt_r, ms_cnt_nxt;
    logic [9:0]  fuse_cnt_r, fuse_cnt_nxt;
    logic        us_tick, ms_tick, period_hit;

    // CRC engine: one 32-bit word per periodic check, bit-serial over 32
    // A period hit while a check is still shifting is skipped, so a short
    // period never cuts a running check short
    logic [5:0]  bit_r, bit_nxt;
    logic        busy_r, busy_nxt;
    logic [15:0] acc_r, acc_nxt;
    logic [31:0] sh_r, sh_nxt;
    logic        fuse_go_r, fuse_go_nxt;

    // Microsecond and millisecond strobes come from the one clock; the
    // period compare uses >= so a period cut below the running count
    // still fires on the next millisecond instead of wrapping
    assign us_tick    = (us_cnt_r == 6'(CYC_PER_US - 1));
    assign ms_tick    = us_tick && (ms_cnt_r == 10'(MS_US - 1));
    assign period_hit = ms_tick && (fuse_cnt_r + 10'h001 >= fuse_r);

    always_comb begin
        keep_nxt   = keep_r;
        cmd_nxt    = cmd_r;
        blank_nxt  = blank_r;
        xcrc_nxt   = xcrc_r;
        exp_nxt    = exp_r;
        seed_nxt   = seed_r;
        poly_nxt   = poly_r;
        wake_nxt   = wake_r;
        crc_en_nxt = crc_en_r;
        thr_nxt    = thr_r;
        fuse_nxt   = fuse_r;
        pin_nxt    = pin_r;
        mode_nxt   = mode_r;
        // Transfer CRC is taken whole from the serial front end; the offset
        // has no write case, so host writes to it are dropped
        if (xfer_crc_vld)
            xcrc_nxt = xfer_crc;
        if (req.wr) begin
            case (req.addr)
                OFS_STANDBY_RAIL:  keep_nxt = req.wdata[0];
                OFS_MODE_CMD: begin
                    cmd_nxt = req.wdata[3:0];
                    // Unlisted codes are kept for read-back only
                    case (req.wdata[3:0])
                        CMD_SELF_CHECK:        mode_nxt = MODE_SELF_CHECK;
                        power_down_entry_code: mode_nxt = MODE_POWER_DOWN;
                        standby_entry_code:    mode_nxt = MODE_STANDBY;
                        ramp_up_entry_code:    mode_nxt = MODE_RAMP_UP;
                        default:               mode_nxt = mode_r;
                    endcase
                end
                OFS_BLANK_A: blank_nxt[27:0]  = req.wdata[27:0];
                OFS_BLANK_B: blank_nxt[55:28] = req.wdata[27:0];
                OFS_SYS_CRC_EXP:   exp_nxt    = req.wdata[15:0];
                OFS_SYS_CRC_POLY: begin
                    seed_nxt = req.wdata[31:16];
                    poly_nxt = req.wdata[15:0];
                end
                OFS_WAKE_FUNC:     wake_nxt   = req.wdata[0];
                OFS_CRC_PERIOD_EN: crc_en_nxt = req.wdata[0];
                OFS_THRESH_TYPE:   thr_nxt    = req.wdata[3:0];
                OFS_FUSE_PERIOD:   fuse_nxt   = req.wdata[9:0];
                OFS_PIN_OVERRIDE:  pin_nxt    = req.wdata[3:0];
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            keep_r   <= RST_RAIL_TWO_KEEP;
            cmd_r    <= 4'h0;
            blank_r  <= {BLANK_FIELDS{RST_BLANK_CODE}};
            xcrc_r   <= 16'h0000;
            exp_r    <= 16'h0000;
            seed_r   <= RST_CRC_SEED;
            poly_r   <= RST_CRC_POLY;
            wake_r   <= 1'b0;
            crc_en_r <= 1'b0;
            thr_r    <= 4'h0;
            fuse_r   <= RST_FUSE_PERIOD;
            pin_r    <= 4'h0;
            mode_r   <= MODE_RAMP_UP;
        end else begin
            keep_r   <= keep_nxt;
            cmd_r    <= cmd_nxt;
            blank_r  <= blank_nxt;
            xcrc_r   <= xcrc_nxt;
            exp_r    <= exp_nxt;
            seed_r   <= seed_nxt;
            poly_r   <= poly_nxt;
            wake_r   <= wake_nxt;
            crc_en_r <= crc_en_nxt;
            thr_r    <= thr_nxt;
            fuse_r   <= fuse_nxt;
            pin_r    <= pin_nxt;
            mode_r   <= mode_nxt;
        end
    end

    // Timebase and periodic CRC engine
    always_comb begin
        us_cnt_nxt   = us_tick ? 6'h00 : us_cnt_r + 6'h01;
        ms_cnt_nxt   = ms_cnt_r;
        fuse_cnt_nxt = fuse_cnt_r;
        fuse_go_nxt  = 1'b0;
        bit_nxt      = bit_r;
        busy_nxt     = busy_r;
        acc_nxt      = acc_r;
        sh_nxt       = sh_r;
        scrc_nxt     = scrc_r;
        fault_nxt    = fault_r;
        if (us_tick)
            ms_cnt_nxt = (ms_cnt_r == 10'(MS_US - 1)) ? 10'h000
                                                      : ms_cnt_r + 10'h001;
        if (ms_tick)
            fuse_cnt_nxt = period_hit ? 10'h000 : fuse_cnt_r + 10'h001;
        if (period_hit) begin
            fuse_go_nxt = 1'b1;
            if (crc_en_r && !busy_r) begin
                busy_nxt = 1'b1;
                bit_nxt  = 6'h00;
                acc_nxt  = seed_r;
                sh_nxt   = sys_word;
            end
        end
        if (busy_r) begin
            // MSB-first Galois step with the programmed generator
            acc_nxt = {acc_r[14:0], 1'b0}
                      ^ ((acc_r[15] ^ sh_r[31]) ? poly_r : 16'h0000);
            sh_nxt  = {sh_r[30:0], 1'b0};
            bit_nxt = bit_r + 6'h01;
            if (bit_r == 6'd31) begin
                busy_nxt  = 1'b0;
                scrc_nxt  = acc_nxt;
                fault_nxt = fault_r | (acc_nxt != exp_r);
            end
        end
        // Fault is sticky until the check is switched off. The clear follows
        // the next enable value so the flag drops with the enable bit; a
        // mismatch landing in that same cycle is dropped with it
        if (!crc_en_nxt)
            fault_nxt = 1'b0;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            us_cnt_r   <= 6'h00;
            ms_cnt_r   <= 10'h000;
            fuse_cnt_r <= 10'h000;
            fuse_go_r  <= 1'b0;
            bit_r      <= 6'h00;
            busy_r     <= 1'b0;
            acc_r      <= 16'h0000;
            sh_r       <= 32'h0000_0000;
            scrc_r     <= 16'h0000;
            fault_r    <= 1'b0;
        end else begin
            us_cnt_r   <= us_cnt_nxt;
            ms_cnt_r   <= ms_cnt_nxt;
            fuse_cnt_r <= fuse_cnt_nxt;
            fuse_go_r  <= fuse_go_nxt;
            bit_r      <= bit_nxt;
            busy_r     <= busy_nxt;
            acc_r      <= acc_nxt;
            sh_r       <= sh_nxt;
            scrc_r     <= scrc_nxt;
            fault_r    <= fault_nxt;
        end
    end

    // Blanking code to microseconds, one decoder per blanking field
    // Codes past the linear range jump to three fixed longer times
    function automatic logic [8:0] blank_us(input logic [3:0] code);
        logic [8:0] us;
        us = 9'h000;
        case (code)
            4'hd:    us = 9'(BLANK_D_US);
            4'he:    us = 9'(BLANK_E_US);
            4'hf:    us = 9'(BLANK_F_US);
            default: us = 9'(({5'h00, code} + 9'h001) * 9'(BLANK_STEP_US));
        endcase
        return us;
    endfunction : blank_us

    for (genvar g = 0; g < BLANK_FIELDS; g++) begin : g_blank
        assign blank_cycles_us[g*9 +: 9] = blank_us(blank_r[g*4 +: 4]);
    end

    // Read mux; reserved bits read zero
    // Combinational so the data stands in the strobe cycle itself; unmapped
    // offsets fall to the default and read as zero
    always_comb begin
        rdata = 32'h0000_0000;
        if (req.rd) begin
            case (req.addr)
                OFS_STANDBY_RAIL:  rdata = {31'h0, keep_r};
                OFS_XFER_CRC:      rdata = {16'h0000, xcrc_r};
                OFS_MODE_CMD:      rdata = {28'h0, cmd_r};
                OFS_BLANK_A:       rdata = {4'h0, blank_r[27:0]};
                OFS_BLANK_B:       rdata = {4'h0, blank_r[55:28]};
                OFS_SYS_CRC:       rdata = {16'h0000, scrc_r};
                OFS_SYS_CRC_EXP:   rdata = {16'h0000, exp_r};
                OFS_SYS_CRC_POLY:  rdata = {seed_r, poly_r};
                OFS_WAKE_FUNC:     rdata = {31'h0, wake_r};
                OFS_CRC_PERIOD_EN: rdata = {31'h0, crc_en_r};
                OFS_THRESH_TYPE:   rdata = {28'h0, thr_r};
                OFS_FUSE_PERIOD:   rdata = {22'h0, fuse_r};
                OFS_PIN_OVERRIDE:  rdata = {28'h0, pin_r};
                default:           rdata = 32'h0000_0000;
            endcase
        end
    end

    assign mode                     = mode_r;
    assign rail_two_standby_keep    = keep_r;
    assign wake_input_event_select  = wake_r;
    // Bit 0 of each pair arms the undervoltage limit and bit 1 the
    // overvoltage limit; with both set the monitor acts as a window
    assign monitor_a_threshold_type = '{uv_en: thr_r[MON_A_LSB],
                                        ov_en: thr_r[MON_A_LSB + 1]};
    assign monitor_b_threshold_type = '{uv_en: thr_r[MON_B_LSB],
                                        ov_en: thr_r[MON_B_LSB + 1]};
    assign fuse_check_start         = fuse_go_r;
    assign sys_crc_fault            = fault_r;
    // Plain mux with no glitch filter: an overridden pin follows its data
    // bit from the cycle after the write
    assign fault_n_pin  = pin_r[0] ? pin_r[1] : fault_n_norm;
    assign status_n_pin = pin_r[2] ? pin_r[3] : status_n_norm;

endmodule : pscr_regs
`default_nettype wire

// >>> pscr_regs_properties.sv
// Assertion checker for the system control register bank
`timescale 1ns/1ps
`default_nettype none
module pscr_regs_chk
    import pscr_pkg::*;
(
    // Clock, reset and register port
    input wire logic        clk,
    input wire logic        rst,
    input wire pscr_req_t   req,
    input wire logic [31:0] rdata,
    // Side inputs
    input wire logic        xfer_crc_vld,
    input wire logic [15:0] xfer_crc,
    input wire logic        fault_n_norm,
    input wire logic        status_n_norm,
    // Outputs watched
    input wire pscr_mode_t  mode,
    input wire logic        rail_two_standby_keep,
    input wire logic        wake_input_event_select,
    input wire pscr_thr_t   monitor_a_threshold_type,
    input wire pscr_thr_t   monitor_b_threshold_type,
    input wire logic [BLANK_FIELDS*9-1:0] blank_cycles_us,
    input wire logic        fuse_check_start,
    input wire logic        sys_crc_fault,
    input wire logic        fault_n_pin,
    input wire logic        status_n_pin
);
    logic [3:0] pin_r;
    logic       en_r;
    wire logic [3:0] cmd = req.wdata[3:0];

    // Shadows of the override and enable registers, snooped from writes
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pin_r <= 4'h0;
            en_r  <= 1'b0;
        end else if (req.wr && req.addr == OFS_PIN_OVERRIDE) begin
            pin_r <= cmd;
        end else if (req.wr && req.addr == OFS_CRC_PERIOD_EN) begin
            en_r <= cmd[0];
        end
    end

    default clocking @(posedge clk); endclocking
    default disable iff (rst);

    sequence s_wr(logic [15:0] a);
        req.wr && req.addr == a;
    endsequence
    sequence s_xfer;
        xfer_crc_vld ##1 !xfer_crc_vld ##1 req.rd && req.addr == OFS_XFER_CRC;
    endsequence

    AST_MODE_SELF:
        assert property (s_wr(OFS_MODE_CMD) ##0 cmd == CMD_SELF_CHECK
            |=> mode == MODE_SELF_CHECK) else $error("self check missed");
    AST_MODE_OTHER:
        assert property (s_wr(OFS_MODE_CMD) ##0 cmd inside {4'h2, 4'h4, 4'h8}
            |=> mode == ($past(cmd) == 4'h2 ? MODE_POWER_DOWN :
            $past(cmd) == 4'h4 ? MODE_STANDBY : MODE_RAMP_UP))
            else $error("mode entry wrong");
    AST_XFER_CRC:
        assert property (s_xfer |-> rdata == {16'h0000, $past(xfer_crc, 2)})
            else $error("transfer crc not held");
    AST_RAIL:
        assert property (s_wr(OFS_STANDBY_RAIL) |=> rail_two_standby_keep
            == $past(cmd[0])) else $error("rail keep bit wrong");
    AST_WAKE:
        assert property (s_wr(OFS_WAKE_FUNC) |=> wake_input_event_select
            == $past(cmd[0])) else $error("wake select wrong");
    AST_THRESH:
        assert property (s_wr(OFS_THRESH_TYPE) |=> {monitor_b_threshold_type.ov_en,
            monitor_b_threshold_type.uv_en, monitor_a_threshold_type.ov_en,
            monitor_a_threshold_type.uv_en} == $past(cmd))
            else $error("threshold type wrong");
    AST_BLANK_LIN:
        assert property (s_wr(OFS_BLANK_A) ##0 cmd <= 4'hc |=> blank_cycles_us[8:0]
            == 9'(BLANK_STEP_US * (int'($past(cmd)) + 1)))
            else $error("blanking time wrong");
    AST_FAULT_PIN:
        assert property (fault_n_pin == (pin_r[0] ? pin_r[1] : fault_n_norm))
            else $error("fault pin drive wrong");
    AST_STATUS_PIN:
        assert property (status_n_pin == (pin_r[2] ? pin_r[3] : status_n_norm))
            else $error("status pin drive wrong");
    AST_CRC_OFF:
        assert property (!en_r |-> !sys_crc_fault)
            else $error("crc fault while disabled");
    AST_FUSE_PULSE:
        assert property (fuse_check_start |=> !fuse_check_start)
            else $error("fuse start not a pulse");
endmodule : pscr_regs_chk

bind pscr_regs pscr_regs_chk i_pscr_regs_chk (.clk(clk), .rst(rst), .req(req),
    .rdata(rdata), .xfer_crc_vld(xfer_crc_vld), .xfer_crc(xfer_crc),
    .fault_n_norm(fault_n_norm), .status_n_norm(status_n_norm), .mode(mode),
    .rail_two_standby_keep(rail_two_standby_keep),
    .wake_input_event_select(wake_input_event_select),
    .monitor_a_threshold_type(monitor_a_threshold_type),
    .monitor_b_threshold_type(monitor_b_threshold_type),
    .blank_cycles_us(blank_cycles_us), .fuse_check_start(fuse_check_start),
    .sys_crc_fault(sys_crc_fault), .fault_n_pin(fault_n_pin),
    .status_n_pin(status_n_pin));
`default_nettype wire

// >>> testbench.sv
// Self-checking bench for the system control register bank
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import pscr_pkg::*;
    typedef struct packed {
        logic [15:0] a;
        logic [31:0] rv;
        logic [31:0] wd;
        logic [31:0] ex;
    } pscr_row_t;
    pscr_row_t rows [14] = '{
        '{16'h80ac, 32'h1, 32'hfffffffe, 32'h0},
        '{16'h80b0, 32'h0, 32'hffffffff, 32'h0},
        '{16'h80b4, 32'h0, 32'hfffffff3, 32'h3},
        '{16'h80b8, 32'h02222222, 32'hffffffff, 32'h0fffffff},
        '{16'h80bc, 32'h02222222, 32'h0, 32'h0},
        '{16'h80c0, 32'h0, 32'hffffffff, 32'h0},
        '{16'h80c4, 32'h0, 32'hffffffff, 32'hffff},
        '{16'h80c8, 32'h555590d9, 32'h12345678, 32'h12345678},
        '{16'h80cc, 32'h0, 32'hffffffff, 32'h1},
        '{16'h80d0, 32'h0, 32'hfffffffe, 32'h0},
        '{16'h80d4, 32'h0, 32'hffffffff, 32'hf},
        '{16'h80d8, 32'h96, 32'hffffffff, 32'h3ff},
        '{16'h80f0, 32'h0, 32'hfffffff0, 32'h0},
        '{16'h80e0, 32'h0, 32'hffffffff, 32'h0}};
    logic [3:0]  cmds [5] = '{4'h2, 4'h1, 4'h4, 4'h8, 4'h1};
    pscr_mode_t  mds [5] = '{MODE_POWER_DOWN, MODE_SELF_CHECK, MODE_STANDBY,
                             MODE_RAMP_UP, MODE_SELF_CHECK};
    logic        clk, rst, vld, fnorm, snorm, rail, wake, fcs, scf, fpin, spin;
    pscr_req_t   req;
    pscr_mode_t  mode;
    pscr_thr_t   thr_a, thr_b;
    logic [31:0] rdata, q, sword, wa, wb;
    logic [15:0] xcrc, crc;
    logic [BLANK_FIELDS*9-1:0] blank;
    int          n_fail, comparisons, t;

    pscr_host i_host (.clk(clk), .req(req), .rdata(rdata));
    pscr_regs i_pscr_regs (.clk(clk), .rst(rst), .req(req), .rdata(rdata),
        .xfer_crc_vld(vld), .xfer_crc(xcrc), .sys_word(sword),
        .fault_n_norm(fnorm), .status_n_norm(snorm), .mode(mode),
        .rail_two_standby_keep(rail), .wake_input_event_select(wake),
        .monitor_a_threshold_type(thr_a), .monitor_b_threshold_type(thr_b),
        .blank_cycles_us(blank), .fuse_check_start(fcs),
        .sys_crc_fault(scf), .fault_n_pin(fpin), .status_n_pin(spin));

    function automatic logic [8:0] us_of(input logic [3:0] c);
        if (c <= 4'hc) return 9'(BLANK_STEP_US * (int'(c) + 1));
        if (c == 4'hd) return 9'(BLANK_D_US);
        if (c == 4'he) return 9'(BLANK_E_US);
        return 9'(BLANK_F_US);
    endfunction : us_of

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_fail++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    task automatic give_verdict;
        $display("comparisons=%0d n_fail=%0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : give_verdict

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    // Hang guard, set well above the roughly 1 ms that the run takes
    initial begin
        #1_900_000;
        n_fail++;
        give_verdict();
    end

    initial begin
        rst = 1'b1;
        {vld, fnorm, snorm, xcrc, sword, wa, wb} = '0;
        repeat (5) @(posedge clk);
        #1 rst = 1'b0;
        chk(mode, MODE_RAMP_UP);
        chk(rail, 1'b1);
        chk({thr_b, thr_a, wake, scf}, 6'h0);
        chk(blank[8:0], 9'h030);
        foreach (rows[i]) begin
            i_host.xfer(0, rows[i].a, 0, q);
            chk(q, rows[i].rv);
            i_host.xfer(1, rows[i].a, rows[i].wd, q);
            i_host.xfer(0, rows[i].a, 0, q);
            chk(q, rows[i].ex);
        end
        chk({rail, wake, mode}, {2'b01, MODE_RAMP_UP});
        foreach (cmds[i]) begin
            i_host.xfer(1, OFS_MODE_CMD, {28'h0, cmds[i]}, q);
            chk(mode, mds[i]);
        end
        for (int c = 0; c < 16; c++) begin
            for (int k = 0; k < 7; k++) begin
                wa[4*k +: 4] = 4'(c + k);
                wb[4*k +: 4] = 4'(c + k + 7);
            end
            i_host.xfer(1, OFS_BLANK_A, wa, q);
            i_host.xfer(1, OFS_BLANK_B, wb, q);
            for (int i = 0; i < BLANK_FIELDS; i++)
                chk(blank[9*i +: 9], us_of(4'(c + i)));
        end
        for (int v = 0; v < 16; v++) begin
            i_host.xfer(1, OFS_THRESH_TYPE, 32'(v), q);
            chk({thr_b.ov_en, thr_b.uv_en, thr_a.ov_en, thr_a.uv_en},
                v);
            for (int n = 0; n < 2; n++) begin
                fnorm = n[0];
                snorm = !n[0];
                i_host.xfer(1, OFS_PIN_OVERRIDE, 32'(v), q);
                chk(fpin, v[0] ? v[1] : n[0]);
                chk(spin, v[2] ? v[3] : !n[0]);
            end
        end
        @(posedge clk);
        #1 vld = 1'b1;
        xcrc = 16'hbeef;
        @(posedge clk);
        #1 vld = 1'b0;
        xcrc = 16'h4110;
        i_host.xfer(0, OFS_XFER_CRC, 0, q);
        chk(q, 32'h0000beef);
        // Golden is deliberately wrong so that the check must flag it
        sword = 32'hc3a50f96;
        crc = RST_CRC_SEED;
        for (int b = 31; b >= 0; b--)
            crc = {crc[14:0], 1'b0}
                  ^ ((crc[15] ^ sword[b]) ? RST_CRC_POLY : 16'h0);
        i_host.xfer(1, OFS_SYS_CRC_POLY, {RST_CRC_SEED, RST_CRC_POLY}, q);
        i_host.xfer(1, OFS_SYS_CRC_EXP, {16'h0, ~crc}, q);
        i_host.xfer(1, OFS_FUSE_PERIOD, 32'h1, q);
        i_host.xfer(1, OFS_CRC_PERIOD_EN, 32'h1, q);
        t = 0;
        while (fcs !== 1'b1 && t < 60000) begin
            @(negedge clk);
            t++;
        end
        if (t >= 60000) begin
            n_fail++;
            give_verdict();
        end
        repeat (34) @(posedge clk);
        i_host.xfer(0, OFS_SYS_CRC, 0, q);
        chk(q, {16'h0, crc});
        chk(scf, 1'b1);
        i_host.xfer(1, OFS_CRC_PERIOD_EN, 32'h0, q);
        chk(scf, 1'b0);
        // Mid-run reset must bring back the reset values and release pins
        rst = 1'b1;
        repeat (2) @(posedge clk);
        #1 rst = 1'b0;
        chk({rail, wake, mode}, {2'b10, MODE_RAMP_UP});
        chk({fpin, spin}, {fnorm, snorm});
        chk(blank[125:117], 9'h030);
        i_host.xfer(0, OFS_SYS_CRC_POLY, 0, q);
        chk(q, {RST_CRC_SEED, RST_CRC_POLY});
        i_host.xfer(0, OFS_FUSE_PERIOD, 0, q);
        chk(q, 32'h0000_0096);
        give_verdict();
    end
endmodule : testbench
`default_nettype wire
